// ==== logic/pzr_pkg.sv ====
// page-zero register bank: offsets, field positions, reset values
// assumes byte-wide register access from a serial protocol engine on clk_sys
package pzr_pkg;
    localparam int unsigned OFFS_W           = 8;
    localparam int unsigned DATA_W           = 8;
    localparam int unsigned PAGE_W           = 8;
    localparam int unsigned FULL_ADDR_W      = 16;
    localparam int unsigned BUS_ADDR_W       = 7;
    localparam int unsigned BUS_ADDR_HI_W    = 5;
    localparam int unsigned PIN_SYNC_W       = 3;

    localparam logic [7:0]  OFS_SILICON_REV  = 8'h00;
    localparam logic [7:0]  OFS_PAGE_SELECT  = 8'h01;
    localparam logic [7:0]  OFS_PART_NUM_LO  = 8'h02;
    localparam logic [7:0]  OFS_PART_NUM_HI  = 8'h03;
    localparam logic [7:0]  OFS_SPEED_GRADE  = 8'h04;
    localparam logic [7:0]  OFS_REV_LETTER   = 8'h05;
    localparam logic [7:0]  OFS_TOOL_VER_0   = 8'h06;
    localparam logic [7:0]  OFS_TOOL_VER_1   = 8'h07;
    localparam logic [7:0]  OFS_TOOL_VER_2   = 8'h08;
    localparam logic [7:0]  OFS_THERMAL      = 8'h09;
    localparam logic [7:0]  OFS_HOUSING      = 8'h0A;
    localparam logic [7:0]  OFS_BUS_ADDR     = 8'h0B;
    localparam logic [7:0]  OFS_FAULT_STAT   = 8'h0C;
    localparam logic [7:0]  OFS_FAULT_STICKY = 8'h11;

    localparam logic [7:0]  PAGE_ZERO        = 8'h00;
    localparam logic [7:0]  PAGE_RESET       = 8'h00;
    localparam logic [7:0]  READ_ZERO        = 8'h00;

    // fault status bit positions
    localparam int unsigned BIT_CAL          = 0;
    localparam int unsigned BIT_OSC_LOST     = 1;
    localparam int unsigned BIT_TIMEOUT      = 5;
    localparam logic [5:0]  FAULT_USED_MASK  = 6'h23;
    localparam int unsigned FAULT_W          = 6;

    // bus address register field 6:2
    localparam int unsigned BUS_ADDR_LSB     = 2;
    localparam int unsigned BUS_ADDR_MSB     = 6;

    // synchronised pin vector layout
    localparam int unsigned PIN_ADDR_LO      = 0;
    localparam int unsigned PIN_ADDR_HI      = 1;
    localparam int unsigned PIN_OSC_LOST     = 2;

    // grade, revision letter and thermal rating codes
    localparam logic [7:0]  GRADE_A          = 8'h00;
    localparam logic [7:0]  GRADE_B          = 8'h01;
    localparam logic [7:0]  GRADE_C          = 8'h02;
    localparam logic [7:0]  GRADE_D          = 8'h03;
    localparam logic [7:0]  REV_LETTER_A     = 8'h00;
    localparam logic [7:0]  REV_LETTER_B     = 8'h01;
    localparam logic [7:0]  THERMAL_INDUSTRIAL = 8'h00;

    localparam logic [7:0]  TOOL_VER_RESET   = 8'h00;
    localparam logic [4:0]  BUS_ADDR_HI_RESET = 5'h1A;
endpackage

// ==== logic/pzr_sync.sv ====
// two-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level; no bus coherency between bits
`timescale 1ns/1ps
module pzr_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } pzr_sync_state_type;

    pzr_sync_state_type state_r;
    pzr_sync_state_type state_nxt;

    always_comb begin
        state_nxt.stage1 = async_in;
        // first stage feeds only the second stage
        state_nxt.stage2 = state_r.stage1;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign sync_out = state_r.stage2;
endmodule

// ==== logic/pzr_regs.sv ====
// page-zero identity and status register bank with mirrored page selector
// assumes a protocol engine on clk_sys issuing single-cycle byte accesses
`timescale 1ns/1ps
module pzr_regs #(
    parameter logic [3:0] SILICON_REV    = 4'h1, // arbitrary value
    parameter logic [7:0] PART_NUM_LO    = 8'h21, // arbitrary value
    parameter logic [7:0] PART_NUM_HI    = 8'h43, // arbitrary value
    parameter logic [7:0] SPEED_GRADE    = pzr_pkg::GRADE_A,
    parameter logic [7:0] REV_LETTER     = pzr_pkg::REV_LETTER_A,
    parameter logic [7:0] THERMAL_RATING = pzr_pkg::THERMAL_INDUSTRIAL,
    parameter logic [7:0] HOUSING        = 8'h01  // arbitrary value
) (
    input  wire logic                                 clk_sys,
    input  wire logic                                 rst,
    input  wire logic                                 acc_valid,
    input  wire logic                                 acc_write,
    input  wire logic [pzr_pkg::OFFS_W-1:0]           acc_offset,
    input  wire logic [pzr_pkg::DATA_W-1:0]           acc_wdata,
    output logic      [pzr_pkg::DATA_W-1:0]           rd_data_r,
    output logic                                      rd_valid_r,
    output logic      [pzr_pkg::FULL_ADDR_W-1:0]      full_addr_r,
    output logic      [pzr_pkg::PAGE_W-1:0]           page_r,
    input  wire logic                                 calibration_active,
    input  wire logic                                 osc_input_signal_lost,
    input  wire logic                                 bus_timeout,
    input  wire logic                                 addr_select_pin_hi,
    input  wire logic                                 addr_select_pin_lo,
    output logic      [pzr_pkg::BUS_ADDR_W-1:0]       bus_address_r
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] page;
        logic [7:0] tool0;
        logic [7:0] tool1;
        logic [7:0] tool2;
        logic [4:0] addr_hi;
        logic [5:0] sticky;
        logic [7:0] rdata;
        logic       rvalid;
        logic [15:0] full_addr;
        logic [6:0] bus_addr;
    } pzr_state_type;

    pzr_state_type state_r;
    pzr_state_type state_nxt;

    logic [pzr_pkg::PIN_SYNC_W-1:0] pins_raw;
    logic [pzr_pkg::PIN_SYNC_W-1:0] pins_sync;
    logic [pzr_pkg::FAULT_W-1:0]    fault_live;
    logic                           page0_acc;

    function automatic logic is_page_sel(input logic [7:0] ofs);
        is_page_sel = (ofs == pzr_pkg::OFS_PAGE_SELECT);
    endfunction

    function automatic logic hits(input logic [7:0] page, input logic [7:0] ofs, input logic [7:0] target);
        hits = (page == pzr_pkg::PAGE_ZERO) && (ofs == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pins and the oscillator monitor come from outside clk_sys
    assign pins_raw = {osc_input_signal_lost, addr_select_pin_hi, addr_select_pin_lo};

    pzr_sync #(
        .WIDTH (pzr_pkg::PIN_SYNC_W)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    always_comb begin
        fault_live = '0;
        fault_live[pzr_pkg::BIT_CAL]      = calibration_active;
        fault_live[pzr_pkg::BIT_OSC_LOST] = pins_sync[pzr_pkg::PIN_OSC_LOST];
        fault_live[pzr_pkg::BIT_TIMEOUT]  = bus_timeout;
    end

    assign page0_acc = (state_r.page == pzr_pkg::PAGE_ZERO);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt        = state_r;
        state_nxt.rvalid = 1'b0;
        // hardware set wins over a same-cycle clear
        state_nxt.sticky = state_r.sticky | fault_live;
        if (acc_valid) begin
            state_nxt.rvalid    = !acc_write;
            state_nxt.full_addr = {state_r.page, acc_offset};
            state_nxt.rdata     = pzr_pkg::READ_ZERO;
            if (acc_write) begin
                if (is_page_sel(acc_offset)) begin
                    state_nxt.page = acc_wdata;
                end
                if (hits(state_r.page, acc_offset, pzr_pkg::OFS_TOOL_VER_0)) begin
                    state_nxt.tool0 = acc_wdata;
                end
                if (hits(state_r.page, acc_offset, pzr_pkg::OFS_TOOL_VER_1)) begin
                    state_nxt.tool1 = acc_wdata;
                end
                if (hits(state_r.page, acc_offset, pzr_pkg::OFS_TOOL_VER_2)) begin
                    state_nxt.tool2 = acc_wdata;
                end
                if (hits(state_r.page, acc_offset, pzr_pkg::OFS_BUS_ADDR)) begin
                    state_nxt.addr_hi = acc_wdata[pzr_pkg::BUS_ADDR_MSB:pzr_pkg::BUS_ADDR_LSB];
                end
                if (hits(state_r.page, acc_offset, pzr_pkg::OFS_FAULT_STICKY)) begin
                    // writing zero clears, writing one keeps
                    state_nxt.sticky = (state_r.sticky & acc_wdata[pzr_pkg::FAULT_W-1:0]
                                        & pzr_pkg::FAULT_USED_MASK) | fault_live;
                end
                // identity and live status offsets have no write path
            end else if (is_page_sel(acc_offset)) begin
                state_nxt.rdata = state_r.page;
            end else if (page0_acc) begin
                case (acc_offset)
                    pzr_pkg::OFS_SILICON_REV:  state_nxt.rdata = {4'h0, SILICON_REV};
                    pzr_pkg::OFS_PART_NUM_LO:  state_nxt.rdata = PART_NUM_LO;
                    pzr_pkg::OFS_PART_NUM_HI:  state_nxt.rdata = PART_NUM_HI;
                    pzr_pkg::OFS_SPEED_GRADE:  state_nxt.rdata = SPEED_GRADE;
                    pzr_pkg::OFS_REV_LETTER:   state_nxt.rdata = REV_LETTER;
                    pzr_pkg::OFS_TOOL_VER_0:   state_nxt.rdata = state_r.tool0;
                    pzr_pkg::OFS_TOOL_VER_1:   state_nxt.rdata = state_r.tool1;
                    pzr_pkg::OFS_TOOL_VER_2:   state_nxt.rdata = state_r.tool2;
                    pzr_pkg::OFS_THERMAL:      state_nxt.rdata = THERMAL_RATING;
                    pzr_pkg::OFS_HOUSING:      state_nxt.rdata = HOUSING;
                    pzr_pkg::OFS_BUS_ADDR:     state_nxt.rdata = {1'b0, state_r.addr_hi, 2'b00};
                    pzr_pkg::OFS_FAULT_STAT:   state_nxt.rdata = {2'b00, fault_live};
                    pzr_pkg::OFS_FAULT_STICKY: state_nxt.rdata = {2'b00, state_r.sticky};
                    default:                   state_nxt.rdata = pzr_pkg::READ_ZERO;
                endcase
            end
        end
        // pins only ever set the two low bits
        state_nxt.bus_addr = {state_nxt.addr_hi, pins_sync[pzr_pkg::PIN_ADDR_HI],
                              pins_sync[pzr_pkg::PIN_ADDR_LO]};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r         <= '0;
            state_r.page    <= pzr_pkg::PAGE_RESET;
            state_r.tool0   <= pzr_pkg::TOOL_VER_RESET;
            state_r.tool1   <= pzr_pkg::TOOL_VER_RESET;
            state_r.tool2   <= pzr_pkg::TOOL_VER_RESET;
            state_r.addr_hi <= pzr_pkg::BUS_ADDR_HI_RESET;
            state_r.bus_addr <= {pzr_pkg::BUS_ADDR_HI_RESET, 2'b00};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rd_data_r     = state_r.rdata;
    assign rd_valid_r    = state_r.rvalid;
    assign full_addr_r   = state_r.full_addr;
    assign page_r        = state_r.page;
    assign bus_address_r = state_r.bus_addr;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    page_write_a: assert property (acc_valid && acc_write && is_page_sel(acc_offset)
        |=> page_r == $past(acc_wdata))
        else $error("page select write not taken");

    page_read_a: assert property (acc_valid && !acc_write && is_page_sel(acc_offset)
        |=> rd_valid_r && rd_data_r == $past(page_r))
        else $error("page select read wrong");

    page_hold_a: assert property (!(acc_valid && acc_write && is_page_sel(acc_offset))
        |=> $stable(page_r))
        else $error("page changed without a write");

    rev_read_a: assert property (acc_valid && !acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_SILICON_REV |=> rd_data_r == {4'h0, SILICON_REV})
        else $error("silicon revision read wrong");

    status_read_a: assert property (acc_valid && !acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_FAULT_STAT |=> rd_data_r[4:2] == 3'b000
        && rd_data_r[pzr_pkg::BIT_TIMEOUT] == $past(bus_timeout)
        && rd_data_r[pzr_pkg::BIT_CAL] == $past(calibration_active))
        else $error("live status read wrong");

    sticky_set_a: assert property (calibration_active
        |=> state_r.sticky[pzr_pkg::BIT_CAL] ##1 state_r.sticky[pzr_pkg::BIT_CAL]
            || $past(acc_valid && acc_write && acc_offset == pzr_pkg::OFS_FAULT_STICKY))
        else $error("sticky calibration flag lost");

    sticky_clear_a: assert property (acc_valid && acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_FAULT_STICKY && !acc_wdata[pzr_pkg::BIT_TIMEOUT] && !bus_timeout
        |=> !state_r.sticky[pzr_pkg::BIT_TIMEOUT])
        else $error("sticky timeout flag not cleared");

    addr_hold_a: assert property (acc_valid && acc_write && acc_offset != pzr_pkg::OFS_BUS_ADDR
        |=> $stable(state_r.addr_hi))
        else $error("bus address changed by another write");

    bus_addr_a: assert property (acc_valid && acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_BUS_ADDR
        |=> bus_address_r[pzr_pkg::BUS_ADDR_MSB:pzr_pkg::BUS_ADDR_LSB]
            == $past(acc_wdata[pzr_pkg::BUS_ADDR_MSB:pzr_pkg::BUS_ADDR_LSB])
        && bus_address_r[1:0] == $past(pins_sync[1:0]))
        else $error("bus address not formed from field and pins");

    full_addr_a: assert property (acc_valid
        |=> full_addr_r == {$past(page_r), $past(acc_offset)})
        else $error("internal address not page then offset");

    part_lo_read_a: assert property (acc_valid && !acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_PART_NUM_LO |=> rd_data_r == PART_NUM_LO)
        else $error("part number low byte read wrong");

    part_hi_read_a: assert property (acc_valid && !acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_PART_NUM_HI |=> rd_data_r == PART_NUM_HI)
        else $error("part number high byte read wrong");

    grade_read_a: assert property (acc_valid && !acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_SPEED_GRADE |=> rd_data_r == SPEED_GRADE)
        else $error("grade code read wrong");

    letter_read_a: assert property (acc_valid && !acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_REV_LETTER |=> rd_data_r == REV_LETTER)
        else $error("revision letter read wrong");

    thermal_read_a: assert property (acc_valid && !acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_THERMAL |=> rd_data_r == THERMAL_RATING)
        else $error("thermal rating read wrong");

    tool_low_write_a: assert property (acc_valid && acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_TOOL_VER_0 |=> state_r.tool0 == $past(acc_wdata))
        else $error("tool version byte 0 not written");

    tool_mid_write_a: assert property (acc_valid && acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_TOOL_VER_1 |=> state_r.tool1 == $past(acc_wdata))
        else $error("tool version byte 1 not written");

    tool_top_write_a: assert property (acc_valid && acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_TOOL_VER_2 |=> state_r.tool2 == $past(acc_wdata))
        else $error("tool version byte 2 not written");

    tool_read_a: assert property (acc_valid && !acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_TOOL_VER_2 |=> rd_data_r == $past(state_r.tool2))
        else $error("tool version byte 2 read wrong");

    osc_status_a: assert property (acc_valid && !acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_FAULT_STAT |=> rd_data_r[pzr_pkg::BIT_OSC_LOST] == $past(pins_sync[pzr_pkg::PIN_OSC_LOST]))
        else $error("oscillator loss status read wrong");

    other_page_a: assert property (acc_valid && !acc_write && !page0_acc
        && !is_page_sel(acc_offset) |=> rd_data_r == pzr_pkg::READ_ZERO)
        else $error("other page read not zero");

    write_silent_a: assert property (acc_valid && acc_write
        |=> !rd_valid_r)
        else $error("write produced a read strobe");

    idle_strobe_a: assert property (!acc_valid
        |=> !rd_valid_r)
        else $error("read strobe without a request");

    sticky_osc_a: assert property (pins_sync[pzr_pkg::PIN_OSC_LOST]
        |=> state_r.sticky[pzr_pkg::BIT_OSC_LOST])
        else $error("sticky oscillator flag not set");

    sticky_tmo_a: assert property (bus_timeout
        |=> state_r.sticky[pzr_pkg::BIT_TIMEOUT])
        else $error("sticky timeout flag not set");

    addr_pins_a: assert property (bus_address_r[1:0] == $past(pins_sync[1:0]))
        else $error("address low bits not from pins");

    page_guard_a: assert property (acc_valid && acc_write && !page0_acc
        |=> $stable(state_r.tool0) && $stable(state_r.addr_hi))
        else $error("write on another page changed page zero");

    page_mirror_c: cover property (acc_valid && acc_write && is_page_sel(acc_offset) && !page0_acc);
    sticky_clear_c: cover property (state_r.sticky[pzr_pkg::BIT_OSC_LOST] ##1
        acc_valid && acc_write && acc_offset == pzr_pkg::OFS_FAULT_STICKY);
    tool_write_c: cover property (acc_valid && acc_write && page0_acc && acc_offset == pzr_pkg::OFS_TOOL_VER_2);
    set_wins_c: cover property (calibration_active && acc_valid && acc_write && page0_acc
        && acc_offset == pzr_pkg::OFS_FAULT_STICKY && !acc_wdata[pzr_pkg::BIT_CAL]);
endmodule

// ==== bench/pzr_host_model.sv ====
// host side of the register port: one byte access at a time
// assumes the bank takes a request at the rising edge and answers reads at that same edge
`timescale 1ns/1ps
module pzr_host_model (
    input  wire logic                        clk_sys,
    output logic                             acc_valid,
    output logic                             acc_write,
    output logic [pzr_pkg::OFFS_W-1:0]       acc_offset,
    output logic [pzr_pkg::DATA_W-1:0]       acc_wdata,
    input  wire logic [pzr_pkg::DATA_W-1:0]  rd_data_r,
    input  wire logic                        rd_valid_r
);
    initial begin
        acc_valid  = 1'b0;
        acc_write  = 1'b0;
        acc_offset = 8'h00;
        acc_wdata  = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    // gap idles before the request, so the host can be prompt or slow
    task automatic xfer(input int gap, input logic wr, input logic [7:0] ofs, input logic [7:0] wd,
                        output logic [7:0] rd, output logic vld);
        repeat (gap) @(negedge clk_sys);
        @(negedge clk_sys);
        acc_valid  = 1'b1;
        acc_write  = wr;
        acc_offset = ofs;
        acc_wdata  = wd;
        @(posedge clk_sys);
        @(negedge clk_sys);
        rd  = rd_data_r;
        vld = rd_valid_r;
        // released lines show the inverse, so a stale value never looks valid
        acc_valid  = 1'b0;
        acc_write  = ~wr;
        acc_offset = ~ofs;
        acc_wdata  = ~wd;
    endtask
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the page-zero register bank
// assumes the bank answers reads at the request edge, half a cycle before the host samples
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys;
    logic        rst;
    logic        acc_valid;
    logic        acc_write;
    logic [7:0]  acc_offset;
    logic [7:0]  acc_wdata;
    logic [7:0]  rd_data_r;
    logic        rd_valid_r;
    logic [15:0] full_addr_r;
    logic [7:0]  page_r;
    logic        cal;
    logic        osc_lost;
    logic        tmo;
    logic        pin_hi;
    logic        pin_lo;
    logic [6:0]  bus_address_r;
    int          n_errors = 0;
    int          samples_checked = 0;
    logic [7:0]  exp_page = 8'h00;

    pzr_regs #(.SPEED_GRADE(pzr_pkg::GRADE_D), .REV_LETTER(pzr_pkg::REV_LETTER_B)) i_pzr_regs (
        .clk_sys(clk_sys), .rst(rst), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_offset(acc_offset), .acc_wdata(acc_wdata), .rd_data_r(rd_data_r),
        .rd_valid_r(rd_valid_r), .full_addr_r(full_addr_r), .page_r(page_r),
        .calibration_active(cal), .osc_input_signal_lost(osc_lost), .bus_timeout(tmo),
        .addr_select_pin_hi(pin_hi), .addr_select_pin_lo(pin_lo), .bus_address_r(bus_address_r));
    pzr_host_model i_pzr_host_model (
        .clk_sys(clk_sys), .acc_valid(acc_valid), .acc_write(acc_write), .acc_offset(acc_offset),
        .acc_wdata(acc_wdata), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        i_pzr_host_model.xfer(ofs[0], 1'b0, ofs, 8'h00, d, v);
        chk_byte({7'h00, v}, 8'h01, "read answer strobe");
        chk_byte(d, exp, "read data");
        chk_word(full_addr_r, {exp_page, ofs}, "internal address");
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] wd);
        logic [7:0] d;
        logic       v;
        i_pzr_host_model.xfer(0, 1'b1, ofs, wd, d, v);
        if (ofs == pzr_pkg::OFS_PAGE_SELECT) begin
            exp_page = wd;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_identity();
        logic [7:0] ofs [7] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h09, 8'h0A};
        logic [7:0] exp [7] = '{8'h01, 8'h21, 8'h43, pzr_pkg::GRADE_D, pzr_pkg::REV_LETTER_B,
                                pzr_pkg::THERMAL_INDUSTRIAL, 8'h01};
        for (int i = 0; i < 7; i++) begin
            rd(ofs[i], exp[i]);
            wr(ofs[i], ~exp[i]);
            rd(ofs[i], exp[i]);
        end
        $display("test identity done");
    endtask
    task automatic t_tool();
        logic [7:0] pat [3] = '{8'hA5, 8'h5A, 8'hFF};
        for (int i = 0; i < 3; i++) begin
            rd(8'h06 + 8'(i), pzr_pkg::TOOL_VER_RESET);
            wr(8'h06 + 8'(i), pat[i]);
            rd(8'h06 + 8'(i), pat[i]);
        end
        $display("test tool version done");
    endtask
    task automatic t_page();
        logic [7:0] pg [3] = '{8'h01, 8'h80, 8'hFF};
        rd(8'h01, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(8'h01, pg[i]);
            chk_byte(page_r, pg[i], "page after write");
            rd(8'h01, pg[i]);
            rd(8'h00, 8'h00);
        end
        wr(8'h06, 8'h11);
        wr(8'h01, 8'h00);
        rd(8'h06, 8'hA5);
        $display("test page done");
    endtask
    task automatic t_bus_addr();
        rd(8'h0B, {1'b0, pzr_pkg::BUS_ADDR_HI_RESET, 2'b00});
        wr(8'h0B, 8'hFF);
        rd(8'h0B, 8'h7C);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_sys);
            pin_hi = i[1];
            pin_lo = i[0];
            repeat (5) @(negedge clk_sys);
            chk_byte({1'b0, bus_address_r}, {1'b0, 5'h1F, i[1:0]}, "serial address");
        end
        $display("test bus address done");
    endtask
    task automatic t_status();
        @(negedge clk_sys);
        cal = 1'b1;
        rd(8'h0C, 8'h01);
        cal = 1'b0;
        tmo = 1'b1;
        rd(8'h0C, 8'h20);
        tmo = 1'b0;
        osc_lost = 1'b1;
        repeat (4) @(negedge clk_sys);
        rd(8'h0C, 8'h02);
        osc_lost = 1'b0;
        repeat (4) @(negedge clk_sys);
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 8'h00);
        rd(8'h11, 8'h23);
        wr(8'h11, 8'hFE);
        rd(8'h11, 8'h22);
        wr(8'h11, 8'h00);
        rd(8'h11, 8'h00);
        // a clear that meets a live event must leave the flag set
        cal = 1'b1;
        wr(8'h11, 8'h00);
        cal = 1'b0;
        rd(8'h11, 8'h01);
        wr(8'h11, 8'h00);
        rd(8'h11, 8'h00);
        $display("test status done");
    endtask
    task automatic t_reset();
        wr(8'h01, 8'h05);
        @(negedge clk_sys);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk_byte(page_r, pzr_pkg::PAGE_RESET, "page in reset");
        chk_byte({1'b0, bus_address_r}, {1'b0, pzr_pkg::BUS_ADDR_HI_RESET, 2'b00}, "addr in reset");
        chk_byte({7'h00, rd_valid_r}, 8'h00, "strobe in reset");
        chk_byte(rd_data_r, 8'h00, "data in reset");
        rst = 1'b0;
        exp_page = pzr_pkg::PAGE_RESET;
        repeat (4) @(negedge clk_sys);
        chk_byte({1'b0, bus_address_r}, {1'b0, pzr_pkg::BUS_ADDR_HI_RESET, 2'b11}, "addr after reset");
        rd(8'h06, pzr_pkg::TOOL_VER_RESET);
        rd(8'h01, pzr_pkg::PAGE_RESET);
        rd(8'h11, 8'h00);
        $display("test reset done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("errors %0d, comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        // whole run is well under 2000 cycles
        #500000;
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        rst = 1'b1;
        cal = 1'b0;
        osc_lost = 1'b0;
        tmo = 1'b0;
        pin_hi = 1'b0;
        pin_lo = 1'b0;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        chk_byte(page_r, pzr_pkg::PAGE_RESET, "page reset value");
        t_identity();
        t_tool();
        t_page();
        t_bus_addr();
        t_status();
        t_reset();
        close_out();
    end
endmodule
